// [logic/mhc_cfg.svh]
`ifndef MHC_CFG_SVH
`define MHC_CFG_SVH
`define MHC_OP_UF_FIRST 8'h40
`define MHC_OP_UF_LAST 8'h47
`define MHC_OP_MVP 8'h04
`define MHC_OP_POSREQ 8'h8a
`define MHC_OP_STOP 8'h80
`define MHC_OP_RUN 8'h81
`define MHC_OP_STEP 8'h82
`define MHC_OP_RESET 8'h83
`define MHC_OP_DL_ENTER 8'h84
`define MHC_OP_DL_EXIT 8'h85
`define MHC_OP_MEMREAD 8'h86
`define MHC_OP_STATUS 8'h87
`define MHC_OP_VERSION 8'h88
`define MHC_OP_FACTORY 8'h89
`define MHC_OP_SWRESET 8'hff
`define MHC_ST_OK 8'h64
`define MHC_ST_REACHED 8'h80
`define MHC_ST_BADVAL 8'h04
`define MHC_HOST_ADDR 8'h02
`define MHC_MAGIC 32'h000004d2
`endif

// [logic/mhc_pkg.sv]
package mhc_pkg;
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] ctype;
        logic [7:0] motor;
        logic [31:0] value;
    } mhc_cmd_t;
    typedef struct packed {
        logic [7:0] tgtAddr;
        logic [7:0] hostAddr;
        logic [7:0] status;
        logic [7:0] command;
        logic [31:0] value;
        logic [7:0] checksum;
        logic special;
        logic [23:0] extra;
    } mhc_reply_t;
    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] sp;
        logic [31:0] accu;
        logic [31:0] xreg;
        logic [7:0] flags;
        logic waitFlag;
    } mhc_prog_t;
    typedef enum logic [1:0] {
        MHC_STOP = 2'b00,
        MHC_RUN = 2'b01,
        MHC_STEP = 2'b10
    } mhc_mode_t;
endpackage

// [logic/mhc_interp.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mhc_cfg.svh"
module mhc_interp #(
    parameter int NMOT = 3,
    parameter int AW = 8,
    parameter logic [7:0] MOD_ADDR = 8'h01,
    // Arbitrary neutral version values
    parameter logic [31:0] VER_BIN = 32'h00010000,
    parameter logic [31:0] VER_STR = 32'h56303031
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cmdValid,
    input wire mhc_pkg::mhc_cmd_t cmd,
    input wire logic [31:0] ufValue,
    input wire logic mvpStrobe,
    input wire logic [2:0] mvpMotor,
    input wire logic [NMOT-1:0] posReached,
    input wire logic execDone,
    input wire mhc_pkg::mhc_prog_t execState,
    input wire logic [AW-1:0] fetchAddr,
    output logic [55:0] fetchWord,
    output logic fwdValid,
    output mhc_pkg::mhc_cmd_t fwdCmd,
    output logic replyValid,
    output mhc_pkg::mhc_reply_t reply,
    output mhc_pkg::mhc_mode_t progMode,
    output mhc_pkg::mhc_prog_t progState,
    output logic dlActive,
    output logic factoryRestore,
    output logic softReset
);
    import mhc_pkg::*;

    generate
        if (NMOT < 1 || NMOT > 8 || AW < 1 || AW > 16) begin : g_chk
            $error("mhc_interp: NMOT must be 1..8 and AW 1..16");
        end
    endgenerate

    function automatic mhc_reply_t mkReply(input logic [7:0] st, input logic [7:0] op,
                                           input logic [31:0] v);
        mkReply = '0;
        mkReply.tgtAddr = MOD_ADDR;
        mkReply.hostAddr = `MHC_HOST_ADDR;
        mkReply.status = st;
        mkReply.command = op;
        mkReply.value = v;
        mkReply.checksum = MOD_ADDR + `MHC_HOST_ADDR + st + op
                           + v[31:24] + v[23:16] + v[15:8] + v[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////////
    logic [55:0] progMem [0:(1<<AW)-1];
    logic [AW-1:0] dlAddr, next_dlAddr;
    logic next_dlActive;
    mhc_mode_t next_progMode;
    mhc_prog_t next_progState;
    logic [NMOT-1:0] armed, next_armed, oneShot, next_oneShot;
    logic [NMOT-1:0] pending, next_pending;
    logic next_replyValid, next_fwdValid, next_factory, next_softReset;
    logic resetDue, next_resetDue;
    mhc_reply_t next_reply;
    mhc_cmd_t next_fwdCmd;
    logic isControl, isUf, memWrite;
    logic [NMOT-1:0] arrived, mvpHit;
    logic [7:0] modeByte;

    always_comb begin
        isControl = (cmd.opcode >= `MHC_OP_STOP && cmd.opcode <= `MHC_OP_POSREQ - 8'h01)
                    || cmd.opcode == `MHC_OP_SWRESET;
        isUf = cmd.opcode >= `MHC_OP_UF_FIRST && cmd.opcode <= `MHC_OP_UF_LAST;
        memWrite = cmdValid && dlActive && !isControl;
        arrived = pending & posReached;
        mvpHit = '0;
        for (int i = 0; i < NMOT; i++) begin
            mvpHit[i] = mvpStrobe && mvpMotor == 3'(i);
        end
        unique case (progMode)
            MHC_RUN: modeByte = 8'h01;
            MHC_STEP: modeByte = 8'h02;
            MHC_STOP: modeByte = dlActive ? 8'h03 : 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Executor updates; a control command in the same cycle overrides only the fields it writes
    always_comb begin
        next_progMode = progMode;
        next_progState = progState;
        next_dlActive = dlActive;
        next_dlAddr = memWrite ? dlAddr + AW'(1) : dlAddr;
        if (execDone && progMode != MHC_STOP) begin
            next_progState = execState;
            if (progMode == MHC_STEP) begin
                next_progMode = MHC_STOP;
            end
        end
        if (cmdValid) begin
            unique case (cmd.opcode)
                `MHC_OP_STOP: next_progMode = MHC_STOP;
                `MHC_OP_RUN: begin
                    next_progMode = MHC_RUN;
                    if (cmd.ctype == 8'h01) begin
                        next_progState.pc = cmd.value[15:0];
                    end
                end
                `MHC_OP_STEP: next_progMode = MHC_STEP;
                `MHC_OP_RESET: begin
                    next_progMode = MHC_STOP;
                    next_progState = '0;
                end
                `MHC_OP_DL_ENTER: begin
                    next_dlActive = 1'b1;
                    next_dlAddr = cmd.value[AW-1:0];
                end
                `MHC_OP_DL_EXIT: next_dlActive = 1'b0;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Notification arming; a move strobe beats a clear in the same cycle
    always_comb begin
        next_armed = armed;
        next_oneShot = oneShot;
        next_pending = pending;
        if (cmdValid && !dlActive && cmd.opcode == `MHC_OP_POSREQ) begin
            next_armed = cmd.value[NMOT-1:0];
            next_oneShot = cmd.ctype == 8'h00 ? cmd.value[NMOT-1:0] : '0;
        end
        if (next_replyValid && next_reply.status == `MHC_ST_REACHED) begin
            next_pending = pending & ~arrived;
        end
        next_pending = next_pending | (mvpHit & armed);
        next_armed = next_armed & ~(mvpHit & oneShot);
    end

    ////////////////////////////////////////////////////////////////////
    // Reply builder; an immediate reply holds a deferred one back a cycle
    always_comb begin
        next_replyValid = 1'b0;
        next_reply = '0;
        next_fwdValid = 1'b0;
        next_fwdCmd = cmd;
        next_factory = 1'b0;
        next_softReset = resetDue;
        next_resetDue = 1'b0;
        if (cmdValid && !memWrite) begin
            next_replyValid = 1'b1;
            next_reply = mkReply(`MHC_ST_OK, cmd.opcode, 32'h0);
            if (isUf) begin
                next_reply = mkReply(`MHC_ST_OK, cmd.opcode, ufValue);
            end else if (cmd.opcode == `MHC_OP_POSREQ) begin
                next_reply = mkReply(`MHC_ST_OK, cmd.opcode,
                                     {24'h0, cmd.value[7:0]});
            end else if (cmd.opcode == `MHC_OP_MEMREAD) begin
                next_reply = mkReply(`MHC_ST_OK, cmd.opcode,
                                     progMem[cmd.value[AW-1:0]][31:0]);
                next_reply.special = 1'b1;
                next_reply.extra = progMem[cmd.value[AW-1:0]][55:32];
            end else if (cmd.opcode == `MHC_OP_STATUS) begin
                unique case (cmd.ctype)
                    8'h00: next_reply.value = {modeByte, 7'h0, progState.waitFlag,
                                               16'(dlAddr)};
                    8'h01: next_reply.value = {modeByte, 7'h0, progState.waitFlag,
                                               progState.pc};
                    8'h02: next_reply.value = progState.accu;
                    8'h03: next_reply.value = progState.xreg;
                    default: next_reply.status = `MHC_ST_BADVAL;
                endcase
                next_reply = mkReply(next_reply.status, cmd.opcode, next_reply.value);
            end else if (cmd.opcode == `MHC_OP_VERSION) begin
                next_reply = mkReply(`MHC_ST_OK, cmd.opcode,
                                     cmd.ctype == 8'h00 ? VER_STR : VER_BIN);
                next_reply.special = cmd.ctype == 8'h00;
            end else if (cmd.opcode == `MHC_OP_FACTORY) begin
                next_replyValid = 1'b0;
                next_factory = cmd.value == `MHC_MAGIC;
            end else if (cmd.opcode == `MHC_OP_SWRESET) begin
                if (cmd.value == `MHC_MAGIC) begin
                    next_resetDue = 1'b1;
                end else begin
                    next_reply.status = `MHC_ST_BADVAL;
                    next_reply = mkReply(next_reply.status, cmd.opcode, 32'h0);
                end
            end else if (!isControl) begin
                next_replyValid = 1'b0;
                next_fwdValid = 1'b1;
            end
        end else if (arrived != '0) begin
            next_replyValid = 1'b1;
            next_reply = mkReply(`MHC_ST_REACHED, `MHC_OP_POSREQ,
                                 {24'h0, 8'(arrived)});
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            progMode <= MHC_STOP;
            progState <= '0;
            dlActive <= 1'b0;
            dlAddr <= '0;
            armed <= '0;
            oneShot <= '0;
            pending <= '0;
            replyValid <= 1'b0;
            reply <= '0;
            fwdValid <= 1'b0;
            fwdCmd <= '0;
            factoryRestore <= 1'b0;
            softReset <= 1'b0;
            resetDue <= 1'b0;
        end else begin
            progMode <= next_progMode;
            progState <= next_progState;
            dlActive <= next_dlActive;
            dlAddr <= next_dlAddr;
            armed <= next_armed;
            oneShot <= next_oneShot;
            pending <= next_pending;
            replyValid <= next_replyValid;
            reply <= next_reply;
            fwdValid <= next_fwdValid;
            fwdCmd <= next_fwdCmd;
            factoryRestore <= next_factory;
            softReset <= next_softReset;
            resetDue <= next_resetDue;
        end
    end

    // Program store has no reset; contents are undefined until downloaded
    always_ff @(posedge clk_sys) begin
        if (memWrite) begin
            progMem[dlAddr] <= {cmd.opcode, cmd.ctype, cmd.motor, cmd.value};
        end
        fetchWord <= progMem[fetchAddr];
    end

    ////////////////////////////////////////////////////////////////////
    uf_reply_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cmdValid && !dlActive && isUf |=> replyValid && reply.status == 8'h64
            && reply.value == $past(ufValue))
        else $error("user opcode reply wrong");

    posreq_now_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cmdValid && !dlActive && cmd.opcode == 8'h8a |=> replyValid
            && reply.status == 8'h64 && reply.hostAddr == 8'h02
            && reply.value == {24'h0, $past(cmd.value[7:0])})
        else $error("immediate reach reply wrong");

    reply_csum_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        replyValid |-> reply.checksum == reply.tgtAddr + reply.hostAddr + reply.status
            + reply.command + reply.value[31:24] + reply.value[23:16]
            + reply.value[15:8] + reply.value[7:0])
        else $error("reply checksum wrong");

    deferred_fmt_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        replyValid && reply.status == 8'h80 |-> reply.command == 8'h8a
            && reply.value[31:8] == 24'h0 && reply.value[7:0] != 8'h0)
        else $error("deferred reply format wrong");

    deferred_due_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (pending & posReached) != '0 && !cmdValid |=> replyValid
            && reply.status == 8'h80)
        else $error("deferred reply missing");

    oneshot_arm_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (oneShot & armed & mvpHit) != '0 && !cmdValid |=>
            (armed & $past(oneShot & mvpHit)) == '0
            && (pending & $past(armed & mvpHit)) == $past(armed & mvpHit))
        else $error("single-shot arm not consumed");

    stop_mode_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cmdValid && cmd.opcode == 8'h80 |=> progMode == MHC_STOP)
        else $error("stop not applied");

    run_addr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cmdValid && cmd.opcode == 8'h81 && cmd.ctype == 8'h01 |=>
            progMode == MHC_RUN && progState.pc == $past(cmd.value[15:0]))
        else $error("run from address wrong");

    step_once_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        progMode == MHC_STEP && execDone && !cmdValid |=> progMode == MHC_STOP)
        else $error("step did not stop");

    reset_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cmdValid && cmd.opcode == 8'h83 |=> progState == '0 && progMode == MHC_STOP)
        else $error("reset did not clear");

    dl_store_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        dlActive && cmdValid && cmd.opcode == 8'h04 |=> !fwdValid
            && (!replyValid || reply.status == 8'h80))
        else $error("download command executed");

    dl_exit_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cmdValid && cmd.opcode == 8'h85 |=> !dlActive)
        else $error("download not left");

    status_accu_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cmdValid && cmd.opcode == 8'h87 && cmd.ctype == 8'h02 |=>
            reply.value == $past(progState.accu))
        else $error("status accumulator wrong");

    memread_fmt_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cmdValid && cmd.opcode == 8'h86 |=> replyValid && reply.special
            && reply.command == 8'h86)
        else $error("memory readback reply wrong");

    version_fmt_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cmdValid && cmd.opcode == 8'h88 |=> replyValid
            && reply.special == ($past(cmd.ctype) == 8'h00)
            && reply.value == (($past(cmd.ctype) == 8'h00) ? VER_STR : VER_BIN))
        else $error("version reply wrong");

    factory_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cmdValid && cmd.opcode == 8'h89 |=> !replyValid
            && factoryRestore == ($past(cmd.value) == 32'h000004d2))
        else $error("factory restore wrong");

    swreset_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cmdValid && cmd.opcode == 8'hff && cmd.value == 32'h000004d2 |=>
            replyValid ##1 softReset)
        else $error("software reset sequence wrong");
endmodule
`default_nettype wire

// [tb/mhc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mhc_host_model (
    input wire logic clk_sys,
    output logic cmdValid,
    output mhc_pkg::mhc_cmd_t cmd,
    input wire logic replyValid,
    input wire mhc_pkg::mhc_reply_t reply
);
    import mhc_pkg::*;
    int replyCount = 0;
    initial begin
        cmdValid = 1'b0;
        cmd = '0;
    end
    always @(posedge clk_sys) begin
        if (replyValid === 1'b1) begin
            replyCount <= replyCount + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Idle edge first, so a strobe never drops and rises in one time step
    task automatic send(input logic [7:0] op, input logic [7:0] ty, input logic [31:0] val);
        @(posedge clk_sys);
        #1;
        cmd.opcode = op;
        cmd.ctype = ty;
        cmd.motor = 8'h00;
        cmd.value = val;
        cmdValid = 1'b1;
        @(posedge clk_sys);
        #1;
        cmdValid = 1'b0;
        // Stale frame must not look valid
        cmd.value = ~val;
    endtask
endmodule
`default_nettype wire

// [tb/motion_host_control_commands_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mhc_cfg.svh"
module motion_host_control_commands_tb;
    import mhc_pkg::*;
    // Arbitrary version values
    localparam logic [31:0] VBIN = 32'h00010000;
    localparam logic [31:0] VSTR = 32'h56303031;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic cmdValid, mvpStrobe, execDone, fwdValid, replyValid, dlActive;
    logic factoryRestore, softReset;
    mhc_cmd_t cmd, fwdCmd;
    mhc_reply_t reply;
    mhc_prog_t execState, progState;
    mhc_mode_t progMode;
    logic [31:0] ufValue = '0;
    logic [2:0] mvpMotor = '0;
    logic [2:0] posReached = '0;
    logic [7:0] fetchAddr = '0;
    logic [55:0] fetchWord;
    int errors = 0;
    int num_checks = 0;
    always #25 clk_sys = ~clk_sys;
    mhc_host_model host (.clk_sys(clk_sys), .cmdValid(cmdValid), .cmd(cmd),
        .replyValid(replyValid), .reply(reply));
    mhc_interp #(.NMOT(3), .AW(8), .MOD_ADDR(8'h01), .VER_BIN(VBIN), .VER_STR(VSTR)) dut (
        .clk_sys(clk_sys), .nrst(nrst), .cmdValid(cmdValid), .cmd(cmd), .ufValue(ufValue),
        .mvpStrobe(mvpStrobe), .mvpMotor(mvpMotor), .posReached(posReached),
        .execDone(execDone), .execState(execState), .fetchAddr(fetchAddr),
        .fetchWord(fetchWord), .fwdValid(fwdValid), .fwdCmd(fwdCmd),
        .replyValid(replyValid), .reply(reply), .progMode(progMode), .progState(progState),
        .dlActive(dlActive), .factoryRestore(factoryRestore), .softReset(softReset));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("Checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wait_reply(input int n, input logic must, output logic got);
        got = 1'b0;
        for (int i = 0; i < n && !got; i++) begin
            if (replyValid === 1'b1) got = 1'b1;
            else tick(1);
        end
        if (must && !got) begin
            errors++;
            wrap_up();
        end
    endtask
    task automatic chk_reply(input logic [7:0] st, input logic [7:0] op, input logic [31:0] v);
        logic [7:0] cs;
        cs = 8'h03 + st + op + v[31:24] + v[23:16] + v[15:8] + v[7:0];
        check(replyValid, 1'b1);
        check({reply.tgtAddr, reply.hostAddr}, {8'h01, `MHC_HOST_ADDR});
        check({reply.status, reply.command, reply.value}, {st, op, v});
        check(reply.checksum, cs);
    endtask
    // Expected mask 0 means the move must stay silent
    task automatic move(input logic [2:0] m, input logic [7:0] exp);
        logic got;
        tick(1);
        mvpMotor = m;
        mvpStrobe = 1'b1;
        tick(1);
        mvpStrobe = 1'b0;
        posReached[m] = 1'b1;
        wait_reply(6, exp != 8'h00, got);
        if (exp != 8'h00) chk_reply(`MHC_ST_REACHED, `MHC_OP_POSREQ, {24'h0, exp});
        else check(got, 1'b0);
        tick(1);
        posReached = '0;
    endtask
    task automatic exec(input logic [15:0] p);
        tick(1);
        execState = '{pc: p, sp: 8'h01, accu: 32'ha5a5a5a5, xreg: 32'h5a5a5a5a,
            flags: 8'h0f, waitFlag: 1'b1};
        execDone = 1'b1;
        tick(1);
        execDone = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_user();
        for (int i = 0; i < 8; i++) begin
            ufValue = 32'h10000000 + i;
            host.send(`MHC_OP_UF_FIRST + 8'(i), 8'h00, 32'h0);
            chk_reply(`MHC_ST_OK, `MHC_OP_UF_FIRST + 8'(i), 32'h10000000 + i);
        end
    endtask
    task automatic t_posreq();
        host.send(`MHC_OP_POSREQ, 8'h01, 32'h5);
        chk_reply(`MHC_ST_OK, `MHC_OP_POSREQ, 32'h5);
        move(3'd0, 8'h01);
        move(3'd0, 8'h01);
        move(3'd2, 8'h04);
        host.send(`MHC_OP_POSREQ, 8'h00, 32'h2);
        chk_reply(`MHC_ST_OK, `MHC_OP_POSREQ, 32'h2);
        move(3'd1, 8'h02);
        move(3'd1, 8'h00);
    endtask
    task automatic t_prog();
        host.send(`MHC_OP_RUN, 8'h01, 32'h10);
        check({progMode, progState.pc}, {MHC_RUN, 16'h0010});
        exec(16'h0011);
        host.send(`MHC_OP_STOP, 8'h00, 32'h0);
        check(progMode, MHC_STOP);
        exec(16'h0022);
        check(progState.pc, 16'h0011);
        host.send(`MHC_OP_STEP, 8'h00, 32'h0);
        exec(16'h0033);
        check({progMode, progState.pc}, {MHC_STOP, 16'h0033});
        check(progState, {16'h0033, 8'h01, 32'ha5a5a5a5, 32'h5a5a5a5a, 8'h0f, 1'b1});
        host.send(`MHC_OP_RUN, 8'h00, 32'h77);
        check({progMode, progState.pc}, {MHC_RUN, 16'h0033});
        host.send(`MHC_OP_STATUS, 8'h01, 32'h0);
        chk_reply(`MHC_ST_OK, `MHC_OP_STATUS, 32'h01010033);
        host.send(`MHC_OP_STATUS, 8'h02, 32'h0);
        chk_reply(`MHC_ST_OK, `MHC_OP_STATUS, 32'ha5a5a5a5);
        host.send(`MHC_OP_STATUS, 8'h03, 32'h0);
        chk_reply(`MHC_ST_OK, `MHC_OP_STATUS, 32'h5a5a5a5a);
        host.send(`MHC_OP_STATUS, 8'h04, 32'h0);
        check(reply.status, `MHC_ST_BADVAL);
        host.send(`MHC_OP_RESET, 8'h00, 32'h0);
        check({progMode, progState}, {MHC_STOP, 97'h0});
        host.send(`MHC_OP_VERSION, 8'h00, 32'h0);
        check({reply.special, reply.value}, {1'b1, VSTR});
        host.send(`MHC_OP_VERSION, 8'h01, 32'h0);
        check({reply.special, reply.value}, {1'b0, VBIN});
    endtask
    task automatic t_download();
        fetchAddr = 8'h05;
        host.send(`MHC_OP_DL_ENTER, 8'h00, 32'h5);
        check(dlActive, 1'b1);
        host.send(`MHC_OP_MVP, 8'h00, 32'h12345678);
        check({replyValid, fwdValid}, 2'b00);
        host.send(`MHC_OP_STATUS, 8'h00, 32'h0);
        chk_reply(`MHC_ST_OK, `MHC_OP_STATUS, 32'h03000006);
        check(fetchWord, {8'h04, 8'h00, 8'h00, 32'h12345678});
        host.send(`MHC_OP_MEMREAD, 8'h00, 32'h5);
        check({reply.special, reply.extra, reply.value},
            {1'b1, 24'h040000, 32'h12345678});
        host.send(`MHC_OP_DL_EXIT, 8'h00, 32'h0);
        check(dlActive, 1'b0);
        host.send(`MHC_OP_MVP, 8'h00, 32'h9);
        check({fwdValid, fwdCmd.value}, {1'b1, 32'h9});
    endtask
    task automatic t_special();
        host.send(`MHC_OP_FACTORY, 8'h00, 32'h000004d1);
        check({factoryRestore, replyValid}, 2'b00);
        host.send(`MHC_OP_FACTORY, 8'h00, `MHC_MAGIC);
        check({factoryRestore, replyValid}, 2'b10);
        host.send(`MHC_OP_SWRESET, 8'h00, 32'h000004d1);
        check(reply.status, `MHC_ST_BADVAL);
        tick(1);
        check(softReset, 1'b0);
        host.send(`MHC_OP_SWRESET, 8'h00, `MHC_MAGIC);
        check(softReset, 1'b0);
        tick(1);
        check(softReset, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mvpStrobe = 1'b0;
        execDone = 1'b0;
        execState = '0;
        repeat (20) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        check({replyValid, dlActive, progMode}, {2'b00, MHC_STOP});
        t_user();
        t_posreq();
        t_prog();
        t_download();
        t_special();
        // Every reply the host saw, factory restores excluded
        check(host.replyCount, 31);
        wrap_up();
    end
endmodule
`default_nettype wire
